// ===== design/dtc_cfg.svh
// Behaviour
// - 8-bit timer A count plus own prescaler
// - internal source: increment every instruction cycle
// - count write blocks increments two cycles
// - source select one: count external pin edges
// - edge select picks rising or falling edge
// - timer A overflow may gate timer B
// - 16-bit timer B wraps, sets irq flag
// - irq needs on, enable, peripheral, global
// - sleep counting only in asynchronous mode
// - overflow in sleep wakes; vector if global
// - timer B oscillator enable holds through sleep
// - capture/compare use timer B count
// - capture event copies count into pair
// - compare match raises event, conversion trigger
// - trigger clears count without setting flag
// - count write beats trigger clear
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_A_COUNT      4'h0
`define DTC_A_CTRL       4'h1
`define DTC_B_LOW        4'h2
`define DTC_B_HIGH       4'h3
`define DTC_B_CTRL       4'h4
`define DTC_FLAGS        4'h5
`define DTC_ENABLES      4'h6
`define DTC_CC_LOW       4'h7
`define DTC_CC_HIGH      4'h8
`define DTC_CC_CTRL      4'h9
`define DTC_A_SRC_BIT    5
`define DTC_A_EDGE_BIT   4
`define DTC_A_PSA_BIT    3
`define DTC_B_ON_BIT     0
`define DTC_B_SYNCD_BIT  2
`define DTC_B_OSC_BIT    3
`define DTC_B_SRC_BIT    6
`define DTC_B_GATE_BIT   7
`define DTC_INH_CYCLES   2'd2
`endif

// ===== design/dtc_pkg.sv
package dtc_pkg;
	typedef enum logic [2:0] {
		DTC_CC_OFF     = 3'b001,
		DTC_CC_CAPTURE = 3'b010,
		DTC_CC_COMPARE = 3'b100
	} dtc_cc_mode_t;
endpackage

// ===== design/dtc_timers.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dtc_timers
	import dtc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       timer_a_ext_clock_pin,
	input  wire logic       timer_b_ext_clock,
	input  wire logic       capture_event,
	input  wire logic       sleeping,
	output logic            irq,
	output logic            wake,
	output logic            conv_trigger,
	output logic            timer_b_osc_run
);
	logic [7:0]   timer_a_count;
	logic [7:0]   a_ctrl;
	logic [7:0]   prescale;
	logic [1:0]   inhibit;
	logic         pin_s1, pin_s2, pin_s3;
	logic [15:0]  timer_b;
	logic [7:0]   timer_b_control;
	logic         b_ext_s1, b_ext_s2, b_ext_s3;
	logic         timer_a_flag;
	logic         timer_b_irq_flag;
	logic         cc_flag;
	logic         timer_b_irq_enable;
	logic         peripheral_irq_enable;
	logic         global_irq_enable;
	logic [15:0]  cc_pair;
	dtc_cc_mode_t cc_mode;

	wire wr_a_count = wr && addr == `DTC_A_COUNT;
	wire wr_a_ctrl  = wr && addr == `DTC_A_CTRL;
	wire wr_b_low   = wr && addr == `DTC_B_LOW;
	wire wr_b_high  = wr && addr == `DTC_B_HIGH;
	wire wr_b_ctrl  = wr && addr == `DTC_B_CTRL;
	wire wr_flags   = wr && addr == `DTC_FLAGS;
	wire wr_en      = wr && addr == `DTC_ENABLES;
	wire wr_cc_low  = wr && addr == `DTC_CC_LOW;
	wire wr_cc_high = wr && addr == `DTC_CC_HIGH;
	wire wr_cc_ctrl = wr && addr == `DTC_CC_CTRL;

	wire a_src  = a_ctrl[`DTC_A_SRC_BIT];
	wire a_edge = a_ctrl[`DTC_A_EDGE_BIT];
	wire a_psa  = a_ctrl[`DTC_A_PSA_BIT];
	wire [2:0] a_ps_sel = a_ctrl[2:0];

	// only s2/s3 are looked at; s1 feeds s2 alone
	wire pin_rise = pin_s2 && !pin_s3;
	wire pin_fall = !pin_s2 && pin_s3;
	wire a_src_tick = a_src ? (a_edge ? pin_fall : pin_rise) : 1'b1;
	wire [7:0] next_prescale = prescale + 8'h01;
	// ratio 2^(sel+1); prescaler rolls on the bit rising edge
	wire ps_tick = a_src_tick && (next_prescale[a_ps_sel] && !prescale[a_ps_sel]);
	wire a_tick = (a_psa ? a_src_tick : ps_tick) && inhibit == 2'd0;
	wire a_wrap = a_tick && timer_a_count == 8'hFF;

	wire b_on    = timer_b_control[`DTC_B_ON_BIT];
	wire b_syncd = timer_b_control[`DTC_B_SYNCD_BIT];
	wire b_src   = timer_b_control[`DTC_B_SRC_BIT];
	wire b_gate  = timer_b_control[`DTC_B_GATE_BIT];
	wire b_ext_rise = b_ext_s2 && !b_ext_s3;
	// synchronous external mode stalls in sleep; the async path keeps running
	wire b_src_tick = b_src ? (b_ext_rise && (b_syncd || !sleeping)) : !sleeping;
	wire b_tick = b_on && b_src_tick && (!b_gate || a_wrap);
	wire b_wrap = b_tick && timer_b == 16'hFFFF;
	wire b_write = wr_b_low || wr_b_high;
	wire cc_match = cc_mode == DTC_CC_COMPARE && timer_b == cc_pair;
	wire trig_clear = cc_match && !b_write;

	wire [15:0] next_timer_b =
		wr_b_low   ? {timer_b[15:8], wdata} :
		wr_b_high  ? {wdata, timer_b[7:0]}  :
		trig_clear ? 16'h0000 :
		b_tick     ? timer_b + 16'h0001 : timer_b;

	wire [7:0] next_rdata =
		!rd                   ? 8'h00 :
		addr == `DTC_A_COUNT  ? timer_a_count :
		addr == `DTC_A_CTRL   ? a_ctrl :
		addr == `DTC_B_LOW    ? timer_b[7:0] :
		addr == `DTC_B_HIGH   ? timer_b[15:8] :
		addr == `DTC_B_CTRL   ? timer_b_control :
		addr == `DTC_FLAGS    ? {5'h00, cc_flag, timer_a_flag, timer_b_irq_flag} :
		addr == `DTC_ENABLES  ? {5'h00, global_irq_enable, peripheral_irq_enable, timer_b_irq_enable} :
		addr == `DTC_CC_LOW   ? cc_pair[7:0] :
		addr == `DTC_CC_HIGH  ? cc_pair[15:8] :
		addr == `DTC_CC_CTRL  ? {5'h00, cc_mode} : 8'h00;

	wire b_irq_cond = timer_b_irq_flag && b_on && timer_b_irq_enable && peripheral_irq_enable;
	assign irq = b_irq_cond && global_irq_enable;
	assign wake = sleeping && b_irq_cond;
	assign conv_trigger = cc_match;
	assign timer_b_osc_run = timer_b_control[`DTC_B_OSC_BIT];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			b_ext_s1 <= 1'b0;
			b_ext_s2 <= 1'b0;
			b_ext_s3 <= 1'b0;
		end else begin
			pin_s1 <= timer_a_ext_clock_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			b_ext_s1 <= timer_b_ext_clock;
			b_ext_s2 <= b_ext_s1;
			b_ext_s3 <= b_ext_s2;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_a_count <= 8'h00;
			a_ctrl <= 8'h08;
			prescale <= 8'h00;
			inhibit <= 2'd0;
		end else begin
			if (wr_a_ctrl)
				a_ctrl <= wdata;
			if (wr_a_count) begin
				timer_a_count <= wdata;
				inhibit <= `DTC_INH_CYCLES;
				prescale <= 8'h00;
			end else begin
				if (inhibit != 2'd0)
					inhibit <= inhibit - 2'd1;
				if (a_src_tick && inhibit == 2'd0)
					prescale <= next_prescale;
				if (a_tick)
					timer_a_count <= timer_a_count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_b <= 16'h0000;
			timer_b_control <= 8'h00;
			cc_pair <= 16'h0000;
			cc_mode <= DTC_CC_OFF;
		end else begin
			timer_b <= next_timer_b;
			if (wr_b_ctrl)
				timer_b_control <= wdata;
			if (wr_cc_ctrl && wdata[2:0] inside {3'b001, 3'b010, 3'b100})
				cc_mode <= dtc_cc_mode_t'(wdata[2:0]);
			if (cc_mode == DTC_CC_CAPTURE && capture_event)
				cc_pair <= timer_b;
			else if (wr_cc_low)
				cc_pair[7:0] <= wdata;
			else if (wr_cc_high)
				cc_pair[15:8] <= wdata;
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_b_irq_flag <= 1'b0;
			timer_a_flag <= 1'b0;
			cc_flag <= 1'b0;
			timer_b_irq_enable <= 1'b0;
			peripheral_irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
			timer_b_irq_flag <= (b_wrap && !trig_clear) || (timer_b_irq_flag && !(wr_flags && !wdata[0]));
			timer_a_flag <= a_wrap || (timer_a_flag && !(wr_flags && !wdata[1]));
			cc_flag <= cc_match || (cc_flag && !(wr_flags && !wdata[2]));
			if (wr_en) begin
				timer_b_irq_enable <= wdata[0];
				peripheral_irq_enable <= wdata[1];
				global_irq_enable <= wdata[2];
			end
		end
	end

	property p_inhibit;
		@(posedge clk) disable iff (!arst_n)
		wr_a_count ##1 !wr_a_count ##1 !wr_a_count |-> $stable(timer_a_count);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("timer A moved during write inhibit");

	property p_a_wrap_flag;
		@(posedge clk) disable iff (!arst_n)
		a_wrap |=> timer_a_flag && timer_a_count == 8'h00;
	endproperty
	a_a_wrap_flag: assert property (p_a_wrap_flag) else $error("timer A wrap lost flag");

	property p_b_wrap;
		@(posedge clk) disable iff (!arst_n)
		b_wrap && !b_write && !cc_match |=> timer_b == 16'h0000 && timer_b_irq_flag;
	endproperty
	a_b_wrap: assert property (p_b_wrap) else $error("timer B wrap wrong");

	property p_irq;
		@(posedge clk) disable iff (!arst_n)
		irq |-> timer_b_irq_flag && b_on && timer_b_irq_enable && peripheral_irq_enable && global_irq_enable;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without all enables");

	property p_trig_clear;
		@(posedge clk) disable iff (!arst_n)
		cc_match && !b_write && !timer_b_irq_flag |=> timer_b == 16'h0000 && !timer_b_irq_flag;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger clear wrong");

	property p_write_wins;
		@(posedge clk) disable iff (!arst_n)
		cc_match && wr_b_low |=> timer_b[7:0] == $past(wdata);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("trigger beat count write");

	property p_capture;
		@(posedge clk) disable iff (!arst_n)
		cc_mode == DTC_CC_CAPTURE && capture_event |=> cc_pair == $past(timer_b);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_sync_pin;
		@(posedge clk) disable iff (!arst_n)
		$rose(timer_a_ext_clock_pin) ##1 timer_a_ext_clock_pin |-> !pin_rise;
	endproperty
	a_sync_pin: assert property (p_sync_pin) else $error("pin edge counted unsynchronised");

	property p_sleep_hold;
		@(posedge clk) disable iff (!arst_n)
		sleeping && !b_src && !b_write && !cc_match |=> $stable(timer_b);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("timer B counted in sleep");

	// the first inhibit check only covers the edge right after the write; this one covers the second
	property p_inhibit_late;
		@(posedge clk) disable iff (!arst_n)
		wr_a_count ##1 !wr_a_count ##1 !wr_a_count |=> timer_a_count == $past(wdata, 3);
	endproperty
	a_inhibit_late: assert property (p_inhibit_late) else $error("timer A moved in second inhibit cycle");

	property p_a_count_write;
		@(posedge clk) disable iff (!arst_n)
		wr_a_count |=> timer_a_count == $past(wdata) && inhibit == `DTC_INH_CYCLES;
	endproperty
	a_a_count_write: assert property (p_a_count_write) else $error("timer A write not taken");

	property p_a_step;
		@(posedge clk) disable iff (!arst_n)
		!a_src && a_psa && inhibit == 2'd0 && !wr_a_count |=> timer_a_count == 8'($past(timer_a_count) + 8'h01);
	endproperty
	a_a_step: assert property (p_a_step) else $error("timer A missed an instruction cycle");

	property p_a_ext_hold;
		@(posedge clk) disable iff (!arst_n)
		a_src && !pin_rise && !pin_fall && !wr_a_count |=> $stable(timer_a_count);
	endproperty
	a_a_ext_hold: assert property (p_a_ext_hold) else $error("timer A counted without a pin edge");

	property p_a_edge;
		@(posedge clk) disable iff (!arst_n)
		a_src && a_edge && pin_rise && !wr_a_count |=> $stable(timer_a_count);
	endproperty
	a_a_edge: assert property (p_a_edge) else $error("timer A counted the unselected edge");

	property p_pin_fall_sync;
		@(posedge clk) disable iff (!arst_n)
		$fell(timer_a_ext_clock_pin) ##1 !timer_a_ext_clock_pin |-> !pin_fall;
	endproperty
	a_pin_fall_sync: assert property (p_pin_fall_sync) else $error("pin fall counted unsynchronised");

	property p_a_flag_sticky;
		@(posedge clk) disable iff (!arst_n)
		timer_a_flag && !wr_flags |=> timer_a_flag;
	endproperty
	a_a_flag_sticky: assert property (p_a_flag_sticky) else $error("timer A flag dropped by itself");

	property p_b_gate;
		@(posedge clk) disable iff (!arst_n)
		b_gate && !a_wrap && !b_write && !cc_match |=> $stable(timer_b);
	endproperty
	a_b_gate: assert property (p_b_gate) else $error("gated timer B moved without timer A wrap");

	property p_b_off;
		@(posedge clk) disable iff (!arst_n)
		!b_on && !b_write && !cc_match |=> $stable(timer_b);
	endproperty
	a_b_off: assert property (p_b_off) else $error("timer B counted while off");

	property p_b_flag_sticky;
		@(posedge clk) disable iff (!arst_n)
		timer_b_irq_flag && !wr_flags |=> timer_b_irq_flag;
	endproperty
	a_b_flag_sticky: assert property (p_b_flag_sticky) else $error("timer B flag dropped by itself");

	property p_async_sleep;
		@(posedge clk) disable iff (!arst_n)
		sleeping && b_on && b_src && b_syncd && !b_gate && b_ext_rise && !b_write && !cc_match
		|=> timer_b == 16'($past(timer_b) + 16'h0001);
	endproperty
	a_async_sleep: assert property (p_async_sleep) else $error("async timer B stalled in sleep");

	property p_wake_no_global;
		@(posedge clk) disable iff (!arst_n)
		sleeping && timer_b_irq_flag && b_on && timer_b_irq_enable && peripheral_irq_enable |-> wake;
	endproperty
	a_wake_no_global: assert property (p_wake_no_global) else $error("overflow in sleep did not wake");

	property p_osc_sleep;
		@(posedge clk) disable iff (!arst_n)
		sleeping && !wr_b_ctrl |=> $stable(timer_b_osc_run);
	endproperty
	a_osc_sleep: assert property (p_osc_sleep) else $error("timer B oscillator changed in sleep");

	property p_conv;
		@(posedge clk) disable iff (!arst_n)
		cc_mode == DTC_CC_COMPARE && timer_b == cc_pair |-> conv_trigger;
	endproperty
	a_conv: assert property (p_conv) else $error("compare match gave no trigger");

	property p_cc_flag;
		@(posedge clk) disable iff (!arst_n)
		cc_match |=> cc_flag;
	endproperty
	a_cc_flag: assert property (p_cc_flag) else $error("compare match left no flag");

	property p_capture_hold;
		@(posedge clk) disable iff (!arst_n)
		cc_mode != DTC_CC_CAPTURE && !wr_cc_low && !wr_cc_high |=> $stable(cc_pair);
	endproperty
	a_capture_hold: assert property (p_capture_hold) else $error("capture pair moved outside capture");

	property p_write_wins_high;
		@(posedge clk) disable iff (!arst_n)
		cc_match && wr_b_high |=> timer_b[15:8] == $past(wdata);
	endproperty
	a_write_wins_high: assert property (p_write_wins_high) else $error("trigger beat high byte write");

	c_a_wrap:  cover property (@(posedge clk) disable iff (!arst_n) a_wrap);
	c_b_wrap:  cover property (@(posedge clk) disable iff (!arst_n) b_wrap);
	c_wake:    cover property (@(posedge clk) disable iff (!arst_n) wake);
	c_capture: cover property (@(posedge clk) disable iff (!arst_n) cc_mode == DTC_CC_CAPTURE && capture_event);
	c_compare: cover property (@(posedge clk) disable iff (!arst_n) conv_trigger);
endmodule

// ===== sim/dtc_ext_src.sv
`timescale 1ns/10ps
module dtc_ext_src (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       start,
	input  wire logic [3:0] pulses,
	output logic            pin
);
	logic [3:0] left;
	logic [1:0] ph;
	// each level lasts three clocks so a two-flop synchroniser cannot miss an edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			left <= 4'h0;
			ph   <= 2'h0;
			pin  <= 1'b0;
		end else if (start) begin
			left <= pulses;
			ph   <= 2'h0;
		end else if (left != 4'h0) begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			if (ph == 2'h2) begin
				pin <= ~pin;
				if (pin)
					left <= left - 4'h1;
			end
		end
	end
endmodule

// ===== sim/dual_timer_counter_block_tb.sv
`timescale 1ns/10ps
`include "dtc_cfg.svh"
`define DTC_CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module dual_timer_counter_block_tb;
	import dtc_pkg::*;
	typedef struct {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} dtc_row_t;
	logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, cap = 1'b0;
	logic       sleeping = 1'b0, start_a = 1'b0, pin_a, irq, wake, conv, osc_run;
	logic [3:0] addr = 4'h0, pulses = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, v, w;
	int         bad_count = 0, check_count = 0;
	dtc_row_t   rows [13] = '{'{4'h1, 1'b0, 8'h00, 8'h08}, '{4'h2, 1'b0, 8'h00, 8'h00},
		'{4'h3, 1'b0, 8'h00, 8'h00}, '{4'h4, 1'b0, 8'h00, 8'h00}, '{4'h5, 1'b0, 8'h00, 8'h00},
		'{4'h6, 1'b0, 8'h00, 8'h00}, '{4'h7, 1'b0, 8'h00, 8'h00}, '{4'h8, 1'b0, 8'h00, 8'h00},
		'{4'hf, 1'b1, 8'hff, 8'h00}, '{4'h2, 1'b1, 8'h5a, 8'h5a}, '{4'h3, 1'b1, 8'ha5, 8'ha5},
		'{4'h7, 1'b1, 8'h12, 8'h12}, '{4'h8, 1'b1, 8'h34, 8'h34}};
	always #5 clk = ~clk;
	dtc_timers dtc_timers_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .timer_a_ext_clock_pin(pin_a), .timer_b_ext_clock(pin_a), .capture_event(cap),
		.sleeping(sleeping), .irq(irq), .wake(wake), .conv_trigger(conv), .timer_b_osc_run(osc_run));
	dtc_ext_src dtc_ext_src_i (.clk(clk), .arst_n(arst_n), .start(start_a), .pulses(pulses), .pin(pin_a));
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#100us;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		#1 `DTC_CHK({irq, wake, conv, osc_run}, 4'h0)
		foreach (rows[i]) begin
			if (rows[i].w)
				wreg(rows[i].a, rows[i].d);
			rreg(rows[i].a, v);
			`DTC_CHK(v, rows[i].e)
		end
		wreg(`DTC_A_COUNT, 8'hf0);
		rreg(`DTC_A_COUNT, v);
		`DTC_CHK(v, 8'hf0)
		rreg(`DTC_A_COUNT, v);
		`DTC_CHK(v, 8'hf1)
		wreg(`DTC_A_COUNT, 8'hff);
		repeat (4) @(posedge clk);
		rreg(`DTC_FLAGS, v);
		`DTC_CHK(v[1], 1'b1)
		// ratio two: reads two cycles apart see exactly one step, whatever the phase
		wreg(`DTC_A_CTRL, 8'h00);
		rreg(`DTC_A_COUNT, v);
		rreg(`DTC_A_COUNT, w);
		`DTC_CHK(w - v, 8'h01)
		for (int e = 0; e < 2; e++) begin
			wreg(`DTC_A_CTRL, e ? 8'h38 : 8'h28);
			wreg(`DTC_A_COUNT, 8'h00);
			@(posedge clk);
			start_a <= 1'b1;
			pulses  <= 4'h5;
			@(posedge clk);
			start_a <= 1'b0;
			repeat (45) @(posedge clk);
			rreg(`DTC_A_COUNT, v);
			`DTC_CHK(v, 8'h05)
		end
		wreg(`DTC_A_CTRL, 8'h08);
		wreg(`DTC_FLAGS, 8'h00);
		wreg(`DTC_B_LOW, 8'hfd);
		wreg(`DTC_B_HIGH, 8'hff);
		wreg(`DTC_ENABLES, 8'h07);
		wreg(`DTC_B_CTRL, 8'h01);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk) #1;
		`DTC_CHK(irq, 1'b1)
		rreg(`DTC_B_HIGH, v);
		`DTC_CHK(v, 8'h00)
		wreg(`DTC_ENABLES, 8'h03);
		#1 `DTC_CHK(irq, 1'b0)
		@(posedge clk);
		sleeping <= 1'b1;
		#1 `DTC_CHK(wake, 1'b1)
		rreg(`DTC_B_LOW, v);
		rreg(`DTC_B_LOW, w);
		`DTC_CHK(w, v)
		wreg(`DTC_B_CTRL, 8'h09);
		#1 `DTC_CHK(osc_run, 1'b1)
		wreg(`DTC_FLAGS, 8'h06);
		#1 `DTC_CHK(wake, 1'b0)
		// external timer B in sleep: synchronised stalls, asynchronous keeps counting
		for (int s = 0; s < 2; s++) begin
			wreg(`DTC_B_CTRL, s ? 8'h4d : 8'h49);
			wreg(`DTC_B_LOW, 8'h00);
			@(posedge clk);
			start_a <= 1'b1;
			@(posedge clk);
			start_a <= 1'b0;
			repeat (40) @(posedge clk);
			rreg(`DTC_B_LOW, v);
			`DTC_CHK(v, s ? 8'h05 : 8'h00)
		end
		@(posedge clk);
		sleeping <= 1'b0;
		wreg(`DTC_B_CTRL, 8'h00);
		wreg(`DTC_B_LOW, 8'h34);
		wreg(`DTC_B_HIGH, 8'h12);
		wreg(`DTC_CC_CTRL, 8'h02);
		@(posedge clk);
		cap <= 1'b1;
		@(posedge clk);
		cap <= 1'b0;
		rreg(`DTC_CC_LOW, v);
		rreg(`DTC_CC_HIGH, w);
		`DTC_CHK({w, v}, 16'h1234)
		wreg(`DTC_A_COUNT, 8'hf8);
		wreg(`DTC_B_LOW, 8'h00);
		wreg(`DTC_B_CTRL, 8'h81);
		repeat (20) @(posedge clk);
		rreg(`DTC_B_LOW, v);
		`DTC_CHK(v, 8'h01)
		wreg(`DTC_FLAGS, 8'h00);
		wreg(`DTC_CC_LOW, 8'h10);
		wreg(`DTC_CC_HIGH, 8'h00);
		wreg(`DTC_B_LOW, 8'h00);
		wreg(`DTC_B_HIGH, 8'h00);
		wreg(`DTC_CC_CTRL, 8'h04);
		wreg(`DTC_B_CTRL, 8'h01);
		for (int i = 0; i < 40 && conv !== 1'b1; i++) @(posedge clk) #1;
		`DTC_CHK(conv, 1'b1)
		rreg(`DTC_B_LOW, v);
		`DTC_CHK(v < 8'h10, 1'b1)
		rreg(`DTC_FLAGS, v);
		`DTC_CHK({v[2], v[0]}, 2'b10)
		// stopped timer parked on the compare value keeps the match up
		wreg(`DTC_B_CTRL, 8'h00);
		wreg(`DTC_CC_LOW, 8'h00);
		wreg(`DTC_B_LOW, 8'h00);
		#1 `DTC_CHK(conv, 1'b1)
		wreg(`DTC_B_LOW, 8'h55);
		rreg(`DTC_B_LOW, v);
		`DTC_CHK(v, 8'h55)
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		#1 `DTC_CHK({irq, wake, conv, osc_run}, 4'h0)
		rreg(`DTC_A_CTRL, v);
		`DTC_CHK(v, 8'h08)
		end_sim();
	end
endmodule
